// file: core/rxe_pkg.sv
package rxe_pkg;

    // clock and traffic-rate window
    localparam int CLK_PERIOD_NS   = 10;
    localparam int RATE_WINDOW_MS  = 1000;
    localparam int RATE_WINDOW_CYC = RATE_WINDOW_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [15:0] RATE_LIMIT_PKTS = 16'h00DC; // 220 packets
    localparam int TIMEOUT_STEP_CYC = 16;

    // receive timeout argument codes
    localparam logic [15:0] TMO_SINGLE     = 16'h0000;
    localparam logic [15:0] TMO_CONTINUOUS = 16'hFFFF;

    // sync word patterns that collide with the modem preamble
    localparam logic [15:0] SYNC_BAD_HI_A   = 16'h8C38;
    localparam logic [15:0] SYNC_BAD_HI_B   = 16'h630E;
    localparam logic [15:0] SYNC_BAD_LO_MAX = 16'h3EFF;

    // register offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_TIMEOUT = 8'h04;
    localparam logic [7:0] REG_SYNC    = 8'h08;
    localparam logic [7:0] REG_CFG     = 8'h0C;
    localparam logic [7:0] REG_STATUS  = 8'h10;
    localparam logic [7:0] REG_MASK    = 8'h14;
    localparam logic [7:0] REG_INFO    = 8'h18;

    // field positions
    localparam int CTRL_RX_START   = 0;
    localparam int CTRL_STANDBY    = 1;
    localparam int CTRL_AUTO_REARM = 2;
    localparam int CFG_CR_LSB      = 0;
    localparam int CFG_MODEM_LSB   = 2;
    localparam int CFG_SYNC_EN     = 4;
    localparam int CFG_HDR_EN      = 5;
    localparam int ST_PKT_OK       = 0;
    localparam int ST_PKT_BAD      = 1;
    localparam int ST_TIMEOUT      = 2;
    localparam int ST_HDR_FAULT    = 3;
    localparam int ST_SYNC_REFUSED = 4;
    localparam int ST_W            = 5;
    localparam int INFO_RX_ACTIVE  = 8;
    localparam int INFO_SINGLE     = 9;
    localparam int INFO_HEAVY      = 10;
    localparam int PKT_CRC_FAIL    = 6;

    typedef enum logic [1:0] {
        OP_RECEIVE_START,
        OP_STANDBY,
        OP_CONFIG
    } rxe_cmd_op_t;

    typedef enum logic [1:0] {
        CR_HALF,
        CR_THREE_QUARTER,
        CR_ONE
    } rxe_coding_rate_t;

    typedef enum logic [1:0] {
        MODEM_LONG_RANGE,
        MODEM_FAST_LONG_RANGE,
        MODEM_FSK
    } rxe_modem_t;

    typedef enum logic {
        RC_OSCILLATOR_STANDBY_STATE,
        RECEIVE_STATE
    } rxe_radio_state_t;

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_CONTINUOUS,
        MODE_TIMED
    } rxe_rx_mode_t;

endpackage : rxe_pkg

// file: core/rxe_link_if.sv
`timescale 1ns/10ps
interface rxe_link_if;
    import rxe_pkg::*;

    // host to device
    logic             cmd_valid;
    rxe_cmd_op_t      cmd_op;
    logic [15:0]      cmd_arg;
    logic [31:0]      cfg_sync_word;
    rxe_coding_rate_t coding_rate;
    rxe_modem_t       cfg_modem;
    logic             cfg_sync_en;
    logic             cfg_hdr_en;
    // device to host
    logic             busy;
    logic             rx_active;
    logic             reception_complete_event;
    logic             reception_timeout_event;
    logic             header_fault_event;
    logic [7:0]       pkt_status;

    modport device_mp (
        input  cmd_valid, cmd_op, cmd_arg, cfg_sync_word, coding_rate,
        input  cfg_modem, cfg_sync_en, cfg_hdr_en,
        output busy, rx_active, reception_complete_event,
        output reception_timeout_event, header_fault_event, pkt_status
    );

    modport host_mp (
        output cmd_valid, cmd_op, cmd_arg, cfg_sync_word, coding_rate,
        output cfg_modem, cfg_sync_en, cfg_hdr_en,
        input  busy, rx_active, reception_complete_event,
        input  reception_timeout_event, header_fault_event, pkt_status
    );

endinterface : rxe_link_if

// file: core/rxe_sync_check.sv
`timescale 1ns/10ps
module rxe_sync_check (
    input  wire logic [31:0]              word,
    input  wire rxe_pkg::rxe_coding_rate_t cr,
    output logic                          forbidden
);
    import rxe_pkg::*;

    logic hi_bad;
    logic lo_bad;

    // upper half against the two preamble-like patterns
    assign hi_bad = (word[31:16] == SYNC_BAD_HI_A)
                 || (word[31:16] == SYNC_BAD_HI_B);
    assign lo_bad = (word[15:0] <= SYNC_BAD_LO_MAX);

    // rate one has no known list, so nothing is refused there
    always_comb begin
        unique case (cr)
            CR_HALF:          forbidden = hi_bad;
            CR_THREE_QUARTER: forbidden = hi_bad || lo_bad;
            CR_ONE:           forbidden = 1'b0;
            default:          forbidden = 1'b1;
        endcase
    end

endmodule : rxe_sync_check

// file: core/rxe_device.sv
`timescale 1ns/10ps
module rxe_device #(
    parameter int STEP_CYC = rxe_pkg::TIMEOUT_STEP_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    rxe_link_if.device_mp    link,
    input  wire logic        modem_pkt_done,
    input  wire logic        modem_crc_fail,
    input  wire logic        modem_hdr_bad,
    input  wire logic        modem_preamble_seen,
    output logic             rx_enable,
    output logic             search_restart,
    output logic [31:0]      modem_sync_word
);
    import rxe_pkg::*;

    typedef struct packed {
        rxe_radio_state_t st;
        rxe_rx_mode_t     mode;
        logic [15:0]      left;
        logic [15:0]      step;
        logic             hdr_hold;
        logic             busy;
        logic             done;
        logic             tmo;
        logic             hfault;
        logic             restart;
        logic [7:0]       pkt_status;
        logic [31:0]      sync_word;
        logic             sync_en;
        logic             hdr_en;
        rxe_modem_t       modem;
    } rxe_dev_state_t;

    localparam rxe_dev_state_t DEV_RST = '{
        st: RC_OSCILLATOR_STANDBY_STATE, mode: MODE_SINGLE,
        modem: MODEM_LONG_RANGE, default: '0};

    rxe_dev_state_t s_q;
    rxe_dev_state_t s_d;

    // command decode, packet events and timeout timer
    always_comb begin
        s_d         = s_q;
        s_d.busy    = 1'b0;
        s_d.done    = 1'b0;
        s_d.tmo     = 1'b0;
        s_d.hfault  = 1'b0;
        s_d.restart = 1'b0;
        if (link.cmd_valid) begin
            s_d.busy = 1'b1;
            unique case (link.cmd_op)
                OP_RECEIVE_START: begin
                    s_d.st       = RECEIVE_STATE;
                    s_d.hdr_hold = 1'b0;
                    s_d.step     = '0;
                    s_d.left     = link.cmd_arg;
                    if (link.cmd_arg == TMO_SINGLE)
                        s_d.mode = MODE_SINGLE;
                    else if (link.cmd_arg == TMO_CONTINUOUS)
                        s_d.mode = MODE_CONTINUOUS;
                    else
                        s_d.mode = MODE_TIMED;
                end
                OP_STANDBY: s_d.st = RC_OSCILLATOR_STANDBY_STATE;
                OP_CONFIG: begin
                    s_d.sync_word = link.cfg_sync_word;
                    s_d.sync_en   = link.cfg_sync_en;
                    s_d.hdr_en    = link.cfg_hdr_en;
                    s_d.modem     = link.cfg_modem;
                end
                default: ;
            endcase
        end else if (s_q.st == RECEIVE_STATE) begin
            if (modem_pkt_done) begin
                // bad payload check still completes; host screens it
                s_d.done                     = 1'b1;
                s_d.pkt_status               = '0;
                s_d.pkt_status[PKT_CRC_FAIL] = modem_crc_fail;
                if (s_q.mode != MODE_CONTINUOUS)
                    s_d.st = RC_OSCILLATOR_STANDBY_STATE;
                s_d.step = '0;
            end else if (s_q.hdr_en && s_q.modem == MODEM_LONG_RANGE
                         && modem_hdr_bad) begin
                // no completion, no timeout: radio sits in receive
                s_d.hfault   = 1'b1;
                s_d.hdr_hold = 1'b1;
            end else if (s_q.sync_en
                         && s_q.modem == MODEM_FAST_LONG_RANGE
                         && modem_preamble_seen) begin
                // preamble-like data mid-packet drops it when sync on
                s_d.restart = 1'b1;
            end else if (s_q.mode == MODE_TIMED && !s_q.hdr_hold) begin
                if (s_q.step == 16'(STEP_CYC - 1)) begin
                    s_d.step = '0;
                    if (s_q.left == 16'h0001) begin
                        s_d.tmo = 1'b1;
                        s_d.st  = RC_OSCILLATOR_STANDBY_STATE;
                    end else begin
                        s_d.left = s_q.left - 16'h0001;
                    end
                end else begin
                    s_d.step = s_q.step + 16'h0001;
                end
            end
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            s_q <= DEV_RST;
        else if (ce)
            s_q <= s_d;
    end

    // outputs straight from the state
    assign link.busy                     = s_q.busy;
    assign link.rx_active                = (s_q.st == RECEIVE_STATE);
    assign link.reception_complete_event = s_q.done;
    assign link.reception_timeout_event  = s_q.tmo;
    assign link.header_fault_event       = s_q.hfault;
    assign link.pkt_status               = s_q.pkt_status;
    assign rx_enable                     = (s_q.st == RECEIVE_STATE);
    assign search_restart                = s_q.restart;
    assign modem_sync_word               = s_q.sync_word;

endmodule : rxe_device

// file: core/rxe_host.sv
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - continuous receive downgraded under heavy traffic
// - continuous receive runs until another command
// - single receive ends in standby after packet
// - single receive re-armed by host after completion; here only when auto_rearm is set or traffic is heavy
// - header fault gives no completion nor timeout
// - host restarts receive on header fault event
// - completion fires even on payload check failure
// - host drops packets flagged with payload failure
// - preamble-like sync word degrades packet error rate
// - sync detection off ignores preamble-like data
// - half rate forbids two upper sync patterns
// - three-quarter rate also forbids low range
module rxe_host #(
    parameter int RATE_WIN_CYC = rxe_pkg::RATE_WINDOW_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             pkt_accept,
    output logic [7:0]       pkt_status_out,
    rxe_link_if.host_mp      link
);
    import rxe_pkg::*;

    typedef struct packed {
        logic             auto_rearm;
        logic [15:0]      tmo_arg;
        logic [31:0]      sync_word;
        rxe_coding_rate_t cr;
        rxe_modem_t       modem;
        logic             sync_en;
        logic             hdr_en;
        logic [ST_W-1:0]  status;
        logic [ST_W-1:0]  mask;
        logic [31:0]      prdata;
        logic             pend_rx;
        logic             pend_stby;
        logic             pend_cfg;
        logic             cmd_valid;
        rxe_cmd_op_t      cmd_op;
        logic [15:0]      cmd_arg;
        logic             single_sent;
        logic [31:0]      win_cnt;
        logic [15:0]      pkt_cnt;
        logic             heavy;
        logic [7:0]       last_pkt;
        logic             accept;
    } rxe_host_state_t;

    localparam rxe_host_state_t HOST_RST = '{
        cr: CR_HALF, modem: MODEM_LONG_RANGE, cmd_op: OP_STANDBY,
        default: '0};

    rxe_host_state_t  h_q;
    rxe_host_state_t  h_d;
    logic             wr_acc;
    logic             rd_setup;
    logic             rd_acc;
    logic             wr_bad;
    logic             cfg_bad;
    rxe_coding_rate_t cfg_cr_in;
    logic [31:0]      rd_val;
    logic [ST_W-1:0]  set;
    logic [15:0]      rx_arg;

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == REG_CTRL) || (a == REG_TIMEOUT) || (a == REG_SYNC)
            || (a == REG_CFG) || (a == REG_STATUS) || (a == REG_MASK)
            || (a == REG_INFO);
    endfunction : addr_mapped

    // apb phases; zero wait states
    assign wr_acc    = psel && penable && pwrite;
    assign rd_setup  = psel && !penable && !pwrite;
    assign rd_acc    = psel && penable && !pwrite;
    assign cfg_cr_in = rxe_coding_rate_t'(pwdata[CFG_CR_LSB +: 2]);
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_mapped(paddr);

    // new sync word under the current rate
    rxe_sync_check u_chk_word (
        .word      (pwdata),
        .cr        (h_q.cr),
        .forbidden (wr_bad)
    );

    // stored sync word under a newly requested rate
    rxe_sync_check u_chk_rate (
        .word      (h_q.sync_word),
        .cr        (cfg_cr_in),
        .forbidden (cfg_bad)
    );

    // read value, captured in the setup phase
    always_comb begin
        rd_val = '0;
        unique case (paddr)
            REG_CTRL:    rd_val[CTRL_AUTO_REARM] = h_q.auto_rearm;
            REG_TIMEOUT: rd_val[15:0] = h_q.tmo_arg;
            REG_SYNC:    rd_val = h_q.sync_word;
            REG_CFG: begin
                rd_val[CFG_CR_LSB +: 2]    = h_q.cr;
                rd_val[CFG_MODEM_LSB +: 2] = h_q.modem;
                rd_val[CFG_SYNC_EN]        = h_q.sync_en;
                rd_val[CFG_HDR_EN]         = h_q.hdr_en;
            end
            REG_STATUS:  rd_val[ST_W-1:0] = h_q.status;
            REG_MASK:    rd_val[ST_W-1:0] = h_q.mask;
            REG_INFO: begin
                rd_val[7:0]           = h_q.last_pkt;
                rd_val[INFO_RX_ACTIVE] = link.rx_active;
                rd_val[INFO_SINGLE]    = h_q.single_sent;
                rd_val[INFO_HEAVY]     = h_q.heavy;
            end
            default:     rd_val = '0;
        endcase
    end

    // register writes, link events, rate watch and command issue
    always_comb begin
        h_d        = h_q;
        h_d.accept = 1'b0;
        set        = '0;
        rx_arg     = h_q.tmo_arg;
        if (rd_setup)
            h_d.prdata = rd_val;
        if (wr_acc) begin
            unique case (paddr)
                REG_CTRL: begin
                    h_d.auto_rearm = pwdata[CTRL_AUTO_REARM];
                    if (pwdata[CTRL_RX_START])
                        h_d.pend_rx = 1'b1;
                    if (pwdata[CTRL_STANDBY]) begin
                        h_d.pend_stby = 1'b1;
                        h_d.pend_rx   = 1'b0;
                    end
                end
                REG_TIMEOUT: h_d.tmo_arg = pwdata[15:0];
                REG_SYNC: begin
                    if (wr_bad) begin
                        set[ST_SYNC_REFUSED] = 1'b1;
                    end else begin
                        h_d.sync_word = pwdata;
                        h_d.pend_cfg  = 1'b1;
                    end
                end
                REG_CFG: begin
                    if (pwdata[CFG_SYNC_EN] && cfg_bad) begin
                        set[ST_SYNC_REFUSED] = 1'b1;
                    end else begin
                        h_d.cr       = cfg_cr_in;
                        h_d.modem    = rxe_modem_t'(
                                       pwdata[CFG_MODEM_LSB +: 2]);
                        h_d.sync_en  = pwdata[CFG_SYNC_EN];
                        h_d.hdr_en   = pwdata[CFG_HDR_EN];
                        h_d.pend_cfg = 1'b1;
                    end
                end
                REG_MASK:    h_d.mask = pwdata[ST_W-1:0];
                default: ;
            endcase
        end
        // completion: screen the status byte before passing it on
        if (link.reception_complete_event) begin
            h_d.last_pkt = link.pkt_status;
            if (h_q.pkt_cnt != 16'hFFFF)
                h_d.pkt_cnt = h_q.pkt_cnt + 16'h0001;
            if (link.pkt_status[PKT_CRC_FAIL]) begin
                set[ST_PKT_BAD] = 1'b1;
            end else begin
                set[ST_PKT_OK] = 1'b1;
                h_d.accept     = 1'b1;
            end
            if (h_q.single_sent && (h_q.auto_rearm || h_q.heavy))
                h_d.pend_rx = 1'b1;
        end
        if (link.reception_timeout_event)
            set[ST_TIMEOUT] = 1'b1;
        // header fault leaves the radio stuck, so kick it again
        if (link.header_fault_event) begin
            set[ST_HDR_FAULT] = 1'b1;
            h_d.pend_rx       = 1'b1;
        end
        // packets per window; heavy flag sets early, clears per window
        if (h_q.pkt_cnt > RATE_LIMIT_PKTS)
            h_d.heavy = 1'b1;
        if (h_q.win_cnt == 32'(RATE_WIN_CYC - 1)) begin
            h_d.win_cnt = '0;
            h_d.pkt_cnt = '0;
            h_d.heavy   = (h_q.pkt_cnt > RATE_LIMIT_PKTS);
        end else begin
            h_d.win_cnt = h_q.win_cnt + 32'h0000_0001;
        end
        // one command at a time, never while the device is busy
        if (h_q.heavy && h_q.tmo_arg == TMO_CONTINUOUS)
            rx_arg = TMO_SINGLE;
        h_d.cmd_valid = 1'b0;
        if (!link.busy && !h_q.cmd_valid) begin
            if (h_q.pend_stby) begin
                h_d.pend_stby = 1'b0;
                h_d.cmd_valid = 1'b1;
                h_d.cmd_op    = OP_STANDBY;
            end else if (h_q.pend_cfg) begin
                h_d.pend_cfg  = 1'b0;
                h_d.cmd_valid = 1'b1;
                h_d.cmd_op    = OP_CONFIG;
            end else if (h_q.pend_rx) begin
                h_d.pend_rx     = 1'b0;
                h_d.cmd_valid   = 1'b1;
                h_d.cmd_op      = OP_RECEIVE_START;
                h_d.cmd_arg     = rx_arg;
                h_d.single_sent = (rx_arg == TMO_SINGLE);
            end
        end
        // read clears only what was shown; a new event still lands
        if (rd_acc && paddr == REG_STATUS)
            h_d.status = (h_q.status & ~h_q.prdata[ST_W-1:0]) | set;
        else
            h_d.status = h_q.status | set;
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            h_q <= HOST_RST;
        else if (ce)
            h_q <= h_d;
    end

    assign prdata             = h_q.prdata;
    assign irq                = |(h_q.status & h_q.mask);
    assign pkt_accept         = h_q.accept;
    assign pkt_status_out     = h_q.last_pkt;
    assign link.cmd_valid     = h_q.cmd_valid;
    assign link.cmd_op        = h_q.cmd_op;
    assign link.cmd_arg       = h_q.cmd_arg;
    assign link.cfg_sync_word = h_q.sync_word;
    assign link.coding_rate   = h_q.cr;
    assign link.cfg_modem     = h_q.modem;
    assign link.cfg_sync_en   = h_q.sync_en;
    assign link.cfg_hdr_en    = h_q.hdr_en;

endmodule : rxe_host

// file: test/rxe_link_sva.sv
`timescale 1ns/10ps
module rxe_link_sva (
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic                   cmd_valid,
    input wire rxe_pkg::rxe_cmd_op_t   cmd_op,
    input wire logic [15:0]            cmd_arg,
    input wire rxe_pkg::rxe_modem_t    cfg_modem,
    input wire logic                   cfg_hdr_en,
    input wire logic                   busy,
    input wire logic                   rx_active,
    input wire logic                   reception_complete_event,
    input wire logic                   reception_timeout_event,
    input wire logic                   header_fault_event
);
    import rxe_pkg::*;
    logic single_q, single_d, cont_q, cont_d;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // remember the mode of the last receive start
    always_comb begin
        single_d = single_q;
        cont_d   = cont_q;
        if (cmd_valid && cmd_op == OP_RECEIVE_START) begin
            single_d = (cmd_arg == TMO_SINGLE);
            cont_d   = (cmd_arg == TMO_CONTINUOUS);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            single_q <= 1'b0;
            cont_q   <= 1'b0;
        end else begin
            single_q <= single_d;
            cont_q   <= cont_d;
        end
    end

    busy_pulse_a: assert property (busy |=> !busy)
        else $error("busy held past one cycle");
    cmd_busy_a: assert property (cmd_valid |=> busy)
        else $error("command not answered by busy");
    cont_stays_a: assert property (reception_complete_event
        && cont_q && !cmd_valid |=> rx_active)
        else $error("continuous receive ended");
    single_end_a: assert property (reception_complete_event
        && single_q |=> !rx_active) else $error("single receive did not stop");
    cmd_gap_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("commands too close");
    hdr_no_done_a: assert property (header_fault_event |->
        !reception_complete_event && !reception_timeout_event)
        else $error("header fault with completion");
    hdr_stay_a: assert property (header_fault_event |-> rx_active)
        else $error("header fault left receive");
    hdr_cfg_a: assert property (header_fault_event |-> cfg_hdr_en &&
        cfg_modem == MODEM_LONG_RANGE) else $error("header fault wrong mode");
    host_rearm_a: assert property (header_fault_event |-> ##[1:6]
        (cmd_valid && cmd_op == OP_RECEIVE_START))
        else $error("no restart after header fault");

    // main scenarios reached
    cover property (reception_complete_event && cont_q);
    cover property (reception_complete_event && single_q);
    cover property (header_fault_event);
endmodule : rxe_link_sva

// file: test/tb.sv
`timescale 1ns/10ps
module tb;
    import rxe_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, irq, err_v;
    logic [7:0]  paddr, pkt_status_out;
    logic [31:0] pwdata, prdata, rd_v, w, sync_w;
    logic        pkt_accept, pkt_done, crc_fail, hdr_bad, c, pre, srst;
    int          err_total, num_checks, cyc, n_done, n_acc, n_hdr;
    int          e_done, e_acc, seed, n_rst;
    rxe_link_if  link ();

    rxe_host #(.RATE_WIN_CYC(200)) rxe_host_i (.clk(clk), .reset_n(reset_n),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .pkt_accept(pkt_accept),
        .pkt_status_out(pkt_status_out), .link(link));
    rxe_device #(.STEP_CYC(4)) rxe_device_i (.clk(clk), .reset_n(reset_n),
        .ce(1'b1), .link(link), .modem_pkt_done(pkt_done),
        .modem_crc_fail(crc_fail), .modem_hdr_bad(hdr_bad),
        .modem_preamble_seen(pre), .rx_enable(), .search_restart(srst),
        .modem_sync_word(sync_w));
    rxe_link_sva rxe_link_sva_i (.clk(clk), .reset_n(reset_n),
        .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op),
        .cmd_arg(link.cmd_arg), .cfg_modem(link.cfg_modem),
        .cfg_hdr_en(link.cfg_hdr_en), .busy(link.busy),
        .rx_active(link.rx_active),
        .reception_complete_event(link.reception_complete_event),
        .reception_timeout_event(link.reception_timeout_event),
        .header_fault_event(link.header_fault_event));

    always #5 clk = ~clk;

    // event counters and hang guard
    always @(posedge clk) begin
        cyc++;
        if (link.reception_complete_event === 1'b1) n_done++;
        if (pkt_accept === 1'b1) n_acc++;
        if (link.header_fault_event === 1'b1) n_hdr++;
        if (srst === 1'b1) n_rst++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer, read data and error taken at the pready edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // one demodulated packet, or a corrupted header
    task automatic pkt(input logic crc, input logic hdr);
        @(posedge clk);
        crc_fail <= crc;
        pkt_done <= !hdr;
        {hdr_bad, pre} <= {2{hdr}};
        @(posedge clk);
        pkt_done <= 1'b0;
        {hdr_bad, pre} <= 2'b00;
        settle(6);
    endtask : pkt

    task automatic start(input logic [15:0] arg);
        apb(1'b1, REG_TIMEOUT, {16'h0000, arg});
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        settle(4);
    endtask : start

    // sync words that collide with the modem preamble
    function automatic logic bad_sync(input int cr, input logic [31:0] x);
        logic hi;
        hi = (x[31:16] == 16'h8C38) || (x[31:16] == 16'h630E);
        if (cr == 0) return hi;
        if (cr == 1) return hi || (x[15:0] <= 16'h3EFF);
        return 1'b0;
    endfunction : bad_sync

    initial begin
        {psel, penable, pwrite, pkt_done, crc_fail, hdr_bad, pre} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        seed = 32'hFC89510F;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, REG_CFG, 32'h0);
        check(rd_v, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        check({err_v, rd_v[0]}, 2'b10);
        apb(1'b1, REG_MASK, 32'h0000_001F);
        // single receive: payload failure first, then a good packet
        for (int i = 0; i < 2; i++) begin
            start(TMO_SINGLE);
            pkt(i == 0, 1'b0);
            e_done++;
            e_acc += (i == 1);
            check(link.rx_active, 1'b0);
            check(pkt_status_out[6], i == 0);
            check(irq, 1'b1);
            apb(1'b0, REG_STATUS, 32'h0);
            check(rd_v[1:0], (i == 0) ? 2'b10 : 2'b01);
            settle(2);
            check(irq, 1'b0);
        end
        // continuous receive survives packets until standby
        start(TMO_CONTINUOUS);
        repeat (3) begin
            c = 1'($random(seed));
            pkt(c, 1'b0);
            e_done++;
            e_acc += !c;
            check(link.rx_active, 1'b1);
        end
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        settle(4);
        check(link.rx_active, 1'b0);
        pkt(1'b0, 1'b0);
        check(n_done, e_done);
        check(n_acc, e_acc);
        // corrupted header stays in receive with no completion
        apb(1'b1, REG_CFG, 32'h0000_0020);
        start(TMO_CONTINUOUS);
        pkt(1'b0, 1'b1);
        check({n_hdr[3:0], n_done[3:0]}, {4'h1, e_done[3:0]});
        check(link.rx_active, 1'b1);
        apb(1'b0, REG_STATUS, 32'h0);
        check(rd_v[3], 1'b1);
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        // sync word screening per coding rate, edges of the low range
        for (int cr = 0; cr < 3; cr++) begin
            apb(1'b1, REG_SYNC, 32'h1234_5678);
            apb(1'b1, REG_CFG, 32'h10 | cr);
            for (int k = 0; k < 4; k++) begin
                w = $random(seed);
                if (k == 0) w[31:16] = 16'h8C38;
                if (k == 1) w[31:16] = 16'h630E;
                if (k == 2) w[15:0] = 16'h3EFF;
                if (k == 3) w[15:0] = 16'h3F00;
                apb(1'b1, REG_SYNC, w);
                apb(1'b0, REG_STATUS, 32'h0);
                check(rd_v[4], bad_sync(cr, w));
            end
        end
        check(sync_w, w);
        // sync on: preamble-like data drops packet; sync off: it does not
        apb(1'b1, REG_CFG, 32'h0000_0016);
        start(TMO_CONTINUOUS);
        pkt(1'b0, 1'b1);
        check(n_rst, 1);
        apb(1'b1, REG_CFG, 32'h0000_0006);
        settle(2);
        pkt(1'b0, 1'b1);
        check(n_rst, 1);
        results();
    end
endmodule : tb
